/* File: ciob_core.sv */
/*
  Execution slice of an 8-bit core: increment with and without skip,
  inclusive OR with literal or file, left shift into carry with zero fill, and the
  unconditional branch with its page-latch fill and flush cycle.
  Assumes instr_word holds the word at fetch_addr whenever instr_valid is
  high, and that program_page_latch is stable while a branch executes.
*/
`timescale 1ns/10ps
module ciob_core (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [ciob_pkg::INSTR_W-1:0] instr_word,
  output logic instr_ready,
  input wire logic [ciob_pkg::PAGE_W-1:0] program_page_latch,
  input wire logic [ciob_pkg::FILE_ADDR_W-1:0] peek_addr,
  output logic [ciob_pkg::DATA_W-1:0] peek_data,
  output logic [ciob_pkg::PC_W-1:0] program_counter,
  output logic [ciob_pkg::DATA_W-1:0] working_reg,
  output logic carry_flag,
  output logic zero_flag,
  output logic nop_cycle,
  output logic retired,
  output logic unknown_op
);

  // All state of the slice except the file register bank
  typedef struct packed {
    ciob_pkg::ciob_state_t state;
    logic [ciob_pkg::PC_W-1:0] pc;
    logic [ciob_pkg::DATA_W-1:0] w;
    logic carry;
    logic zero;
    logic nop;
    logic retired;
    logic unknown;
  } ciob_core_state_t;

  ciob_core_state_t s_q;
  ciob_core_state_t s_d;

  ciob_pkg::ciob_op_t op;
  logic take;
  logic dest_file;
  logic [ciob_pkg::FILE_ADDR_W-1:0] f_addr;
  logic [ciob_pkg::DATA_W-1:0] lit;
  logic [ciob_pkg::BRANCH_K_W-1:0] branch_k;
  logic [ciob_pkg::DATA_W-1:0] f_val;
  logic [ciob_pkg::DATA_W-1:0] alu_result;
  logic alu_carry;
  logic alu_zero;
  logic alu_write_w;
  logic alu_write_f;
  logic alu_upd_zero;
  logic alu_upd_carry;
  logic [ciob_pkg::PC_W-1:0] pc_next;
  logic [ciob_pkg::PC_W-1:0] pc_skip;
  logic [ciob_pkg::PC_W-1:0] pc_branch;

  // An instruction is taken only in the execute state; a flush cycle refuses it
  assign instr_ready = (s_q.state == ciob_pkg::CIOB_ST_EXEC);
  assign take = instr_ready & instr_valid;

  // Field extraction from the instruction word
  assign op = take ? ciob_pkg::ciob_decode(instr_word) : ciob_pkg::CIOB_OP_NONE;
  assign dest_file = instr_word[ciob_pkg::DEST_BIT];
  assign f_addr = instr_word[ciob_pkg::FILE_ADDR_LSB +: ciob_pkg::FILE_ADDR_W];
  assign lit = instr_word[ciob_pkg::LIT_LSB +: ciob_pkg::DATA_W];
  assign branch_k = instr_word[ciob_pkg::BRANCH_K_W-1:0];

  // Sequential and skipping addresses wrap at the top of program space
  assign pc_next = s_q.pc + ciob_pkg::PC_W'(ciob_pkg::PC_STEP_ONE);
  assign pc_skip = s_q.pc + ciob_pkg::PC_W'(2);
  // Upper bits come from the wide page-latch field, not only its low two bits
  assign pc_branch = {program_page_latch[ciob_pkg::PAGE_HI:ciob_pkg::PAGE_LO], branch_k};

  ciob_file_bank u_bank (
    .clk(clk),
    .rd_addr(f_addr),
    .rd_data(f_val),
    .peek_addr(peek_addr),
    .peek_data(peek_data),
    .wr_en(alu_write_f),
    .wr_addr(f_addr),
    .wr_data(alu_result)
  );

  ciob_alu u_alu (
    .op(op),
    .dest_file(dest_file),
    .w_val(s_q.w),
    .f_val(f_val),
    .lit(lit),
    .result(alu_result),
    .carry_out(alu_carry),
    .zero_out(alu_zero),
    .write_w(alu_write_w),
    .write_f(alu_write_f),
    .upd_zero(alu_upd_zero),
    .upd_carry(alu_upd_carry)
  );

  // Next-state logic: datapath writeback, flags and program counter flow
  always_comb begin
    s_d = s_q;
    s_d.nop = 1'b0;
    s_d.retired = 1'b0;
    s_d.unknown = 1'b0;
    case (s_q.state)
      ciob_pkg::CIOB_ST_EXEC: begin
        if (take) begin
          s_d.retired = 1'b1;
          s_d.pc = pc_next;
          if (alu_write_w) begin
            s_d.w = alu_result;
          end
          if (alu_upd_zero) begin
            s_d.zero = alu_zero;
          end
          if (alu_upd_carry) begin
            s_d.carry = alu_carry;
          end
          case (op)
            ciob_pkg::CIOB_OP_INCREMENT_SKIP: begin
              // Zero result: step over the next word and spend a no-op cycle
              if (alu_zero) begin
                s_d.pc = pc_skip;
                s_d.state = ciob_pkg::CIOB_ST_FLUSH;
              end
            end
            ciob_pkg::CIOB_OP_BRANCH: begin
              s_d.pc = pc_branch;
              s_d.state = ciob_pkg::CIOB_ST_FLUSH;
            end
            ciob_pkg::CIOB_OP_NONE: begin
              // Words outside this slice advance the counter and are flagged
              s_d.unknown = 1'b1;
            end
            default: begin
              s_d.state = ciob_pkg::CIOB_ST_EXEC;
            end
          endcase
        end
      end
      ciob_pkg::CIOB_ST_FLUSH: begin
        // Second cycle of a branch or a skip: nothing executes
        s_d.nop = 1'b1;
        s_d.state = ciob_pkg::CIOB_ST_EXEC;
      end
      default: begin
        s_d.state = ciob_pkg::CIOB_ST_EXEC;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q.state <= ciob_pkg::CIOB_ST_EXEC;
      s_q.pc <= ciob_pkg::PC_RESET;
      s_q.w <= ciob_pkg::W_RESET;
      s_q.carry <= 1'b0;
      s_q.zero <= 1'b0;
      s_q.nop <= 1'b0;
      s_q.retired <= 1'b0;
      s_q.unknown <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Observed state comes straight from flip-flops
  assign program_counter = s_q.pc;
  assign working_reg = s_q.w;
  assign carry_flag = s_q.carry;
  assign zero_flag = s_q.zero;
  assign nop_cycle = s_q.nop;
  assign retired = s_q.retired;
  assign unknown_op = s_q.unknown;

endmodule : ciob_core

/* File: ciob_pkg.sv */
/*
  Shared constants, types and decode function for the increment, inclusive-OR,
  left-shift and branch execution slice of an 8-bit core.
  Assumes a 14-bit instruction word presented at the fetch address and one
  instruction cycle per clock edge.
*/
// Function
// - Increment file register; d=0 result to working register, d=1 back to file.
// - Increment-skip: nonzero result runs next instruction; zero result runs a no-op.
// - Branch loads its 11-bit immediate into program counter bits 10:0.
// - Branch fills program counter bits 14:11 from page latch bits 6:3.
// - Branch always takes two instruction cycles.
// - OR literal: working register OR 8-bit literal, result to working register.
// - OR file: working OR file register; d selects working or file destination.
// - Left shift: file bit 7 into carry, bits 6:0 into result bits 7:1.
// - Left shift inserts zero into result bit 0.
// - Left shift result to working register when d=0, file register when d=1.
// - File operands use a 7-bit address, 0 through 127 of current bank.
package ciob_pkg;

  // Data path and address widths
  localparam int DATA_W = 8;
  localparam int INSTR_W = 14;
  localparam int FILE_ADDR_W = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PC_W = 15;
  localparam int PAGE_W = 7;
  localparam int BRANCH_K_W = 11;

  // Field positions inside the instruction word and the page latch
  localparam int DEST_BIT = 7;
  localparam int FILE_ADDR_LSB = 0;
  localparam int LIT_LSB = 0;
  localparam int PAGE_HI = 6;
  localparam int PAGE_LO = 3;

  // Opcode patterns: byte-oriented ops match on bits 13:8
  localparam logic [5:0] OPC_INCREMENT_FILE = 6'h0A;
  localparam logic [5:0] OPC_INCREMENT_SKIP = 6'h0F;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_OR_LITERAL = 6'h38;
  localparam logic [5:0] OPC_SHIFT_LEFT = 6'h35;
  // Branch matches on bits 13:11
  localparam logic [2:0] OPC_BRANCH = 3'h5;

  // Values after reset, and the program counter step
  localparam logic [DATA_W-1:0] W_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
  localparam logic PC_STEP_ONE = 1'b1;

  // Operation selected by the decoder
  typedef enum logic [2:0] {
    CIOB_OP_NONE = 3'h0,
    CIOB_OP_INCREMENT_FILE = 3'h1,
    CIOB_OP_INCREMENT_SKIP = 3'h2,
    CIOB_OP_OR_LITERAL = 3'h3,
    CIOB_OP_OR_FILE = 3'h4,
    CIOB_OP_SHIFT_LEFT = 3'h5,
    CIOB_OP_BRANCH = 3'h6
  } ciob_op_t;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    CIOB_ST_EXEC = 2'h1,
    CIOB_ST_FLUSH = 2'h2
  } ciob_state_t;

  // Map an instruction word onto the operations handled here
  function automatic ciob_op_t ciob_decode(input logic [INSTR_W-1:0] instr);
    ciob_op_t op;
    op = CIOB_OP_NONE;
    if (instr[13:11] == OPC_BRANCH) begin
      op = CIOB_OP_BRANCH;
    end else begin
      case (instr[13:8])
        OPC_INCREMENT_FILE: op = CIOB_OP_INCREMENT_FILE;
        OPC_INCREMENT_SKIP: op = CIOB_OP_INCREMENT_SKIP;
        OPC_OR_FILE: op = CIOB_OP_OR_FILE;
        OPC_OR_LITERAL: op = CIOB_OP_OR_LITERAL;
        OPC_SHIFT_LEFT: op = CIOB_OP_SHIFT_LEFT;
        default: op = CIOB_OP_NONE;
      endcase
    end
    return op;
  endfunction : ciob_decode

endpackage : ciob_pkg

/* File: ciob_alu.sv */
/*
  Combinational arithmetic for the increment, OR and left-shift operations,
  with destination selection and flag update enables.
  Assumes operands are stable for the whole instruction cycle.
*/
`timescale 1ns/10ps
module ciob_alu (
  input wire ciob_pkg::ciob_op_t op,
  input wire logic dest_file,
  input wire logic [ciob_pkg::DATA_W-1:0] w_val,
  input wire logic [ciob_pkg::DATA_W-1:0] f_val,
  input wire logic [ciob_pkg::DATA_W-1:0] lit,
  output logic [ciob_pkg::DATA_W-1:0] result,
  output logic carry_out,
  output logic zero_out,
  output logic write_w,
  output logic write_f,
  output logic upd_zero,
  output logic upd_carry
);

  // Result, then destination and flags from the operation class
  always_comb begin
    result = f_val;
    carry_out = 1'b0;
    write_w = 1'b0;
    write_f = 1'b0;
    upd_zero = 1'b0;
    upd_carry = 1'b0;
    case (op)
      ciob_pkg::CIOB_OP_INCREMENT_FILE: begin
        result = f_val + 8'h01;
        write_w = ~dest_file;
        write_f = dest_file;
        upd_zero = 1'b1;
      end
      ciob_pkg::CIOB_OP_INCREMENT_SKIP: begin
        result = f_val + 8'h01;
        write_w = ~dest_file;
        write_f = dest_file;
      end
      ciob_pkg::CIOB_OP_OR_LITERAL: begin
        result = w_val | lit;
        write_w = 1'b1;
        upd_zero = 1'b1;
      end
      ciob_pkg::CIOB_OP_OR_FILE: begin
        result = w_val | f_val;
        write_w = ~dest_file;
        write_f = dest_file;
        upd_zero = 1'b1;
      end
      ciob_pkg::CIOB_OP_SHIFT_LEFT: begin
        result = {f_val[6:0], 1'b0};
        carry_out = f_val[7];
        write_w = ~dest_file;
        write_f = dest_file;
        upd_zero = 1'b1;
        upd_carry = 1'b1;
      end
      default: begin
        result = f_val;
      end
    endcase
    zero_out = (result == 8'h00);
  end

endmodule : ciob_alu

/* File: ciob_file_bank.sv */
/*
  The 128-byte current bank of file registers: one combinational read port
  for the operand, one for observation, and one synchronous write port.
  Assumes bank switching is handled outside; contents are not reset.
*/
`timescale 1ns/10ps
module ciob_file_bank (
  input wire logic clk,
  input wire logic [ciob_pkg::FILE_ADDR_W-1:0] rd_addr,
  output logic [ciob_pkg::DATA_W-1:0] rd_data,
  input wire logic [ciob_pkg::FILE_ADDR_W-1:0] peek_addr,
  output logic [ciob_pkg::DATA_W-1:0] peek_data,
  input wire logic wr_en,
  input wire logic [ciob_pkg::FILE_ADDR_W-1:0] wr_addr,
  input wire logic [ciob_pkg::DATA_W-1:0] wr_data
);

  logic [ciob_pkg::DATA_W-1:0] mem [ciob_pkg::FILE_DEPTH];

  // Reads see the stored value; a write lands at the end of the cycle
  assign rd_data = mem[rd_addr];
  assign peek_data = mem[peek_addr];

  // No reset: a RAM bank powers up undefined, software initialises it
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule : ciob_file_bank

/* File: ciob_core_props.sv */
/*
  Port-level checker for ciob_core: datapath results, flags, branch target and flush timing.
  Assumes the bench keeps peek_addr on the operand address of the word it presents.
*/
`timescale 1ns/10ps
module ciob_core_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [ciob_pkg::INSTR_W-1:0] instr_word,
  input wire logic instr_ready,
  input wire logic [ciob_pkg::PAGE_W-1:0] program_page_latch,
  input wire logic [ciob_pkg::FILE_ADDR_W-1:0] peek_addr,
  input wire logic [ciob_pkg::DATA_W-1:0] peek_data,
  input wire logic [ciob_pkg::PC_W-1:0] program_counter,
  input wire logic [ciob_pkg::DATA_W-1:0] working_reg,
  input wire logic carry_flag,
  input wire logic zero_flag,
  input wire logic nop_cycle,
  input wire logic retired,
  input wire logic unknown_op
);
  logic take;
  logic opnd;
  logic [5:0] opc;
  // Operand is only trusted when the peek port looks at the same address
  assign take = instr_ready & instr_valid;
  assign opc = instr_word[13:8];
  assign opnd = take & (peek_addr == instr_word[6:0]);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // One refused cycle, then ready again with the no-op marker
  sequence flush_then_resume;
    !instr_ready ##1 (instr_ready && nop_cycle);
  endsequence
  a_branch_target: assert property (
    take && instr_word[13:11] == ciob_pkg::OPC_BRANCH |=>
    program_counter == {$past(program_page_latch[6:3]), $past(instr_word[10:0])}) else $error("branch target wrong");
  a_branch_flush: assert property (
    take && instr_word[13:11] == ciob_pkg::OPC_BRANCH |=> flush_then_resume) else $error("branch not two cycles");
  a_orlit_value: assert property (
    take && opc == ciob_pkg::OPC_OR_LITERAL |=> working_reg == ($past(working_reg) | $past(instr_word[7:0]))
    && zero_flag == (working_reg == 8'h00)) else $error("or literal wrong");
  a_orfile_value: assert property (
    opnd && opc == ciob_pkg::OPC_OR_FILE && !instr_word[7] |=>
    working_reg == ($past(working_reg) | $past(peek_data))) else $error("or file wrong");
  a_increment_file_value: assert property (
    opnd && opc == ciob_pkg::OPC_INCREMENT_FILE && !instr_word[7] |=>
    working_reg == $past(peek_data) + 8'h01 && zero_flag == (working_reg == 8'h00)) else $error("increment wrong");
  a_shift_carry: assert property (
    opnd && opc == ciob_pkg::OPC_SHIFT_LEFT |=> carry_flag == $past(peek_data[7])
    && zero_flag == ($past(peek_data[6:0]) == 7'h00)) else $error("shift flags wrong");
  a_shift_to_w: assert property (
    opnd && opc == ciob_pkg::OPC_SHIFT_LEFT && !instr_word[7] |=>
    working_reg == {$past(peek_data[6:0]), 1'h0}) else $error("shift result wrong");
  a_skip_zero: assert property (
    opnd && opc == ciob_pkg::OPC_INCREMENT_SKIP && peek_data == 8'hFF |=> flush_then_resume) else $error("no skip");
  a_skip_nonzero: assert property (
    opnd && opc == ciob_pkg::OPC_INCREMENT_SKIP && peek_data != 8'hFF |=>
    instr_ready && program_counter == $past(program_counter) + 15'h0001) else $error("bad skip");
  a_skip_flags: assert property (
    take && opc == ciob_pkg::OPC_INCREMENT_SKIP |=> $stable(carry_flag) && $stable(zero_flag)) else $error("skip flags");
  a_flush_refuses: assert property (
    !instr_ready && instr_valid |=> !retired && $stable(working_reg)) else $error("flush took a word");
endmodule : ciob_core_props

bind ciob_core ciob_core_props ciob_core_props_i (.clk, .rst_n, .instr_valid, .instr_word, .instr_ready,
  .program_page_latch, .peek_addr, .peek_data, .program_counter, .working_reg, .carry_flag, .zero_flag,
  .nop_cycle, .retired, .unknown_op);

/* File: tb_ciob_core.sv */
/*
  Self-checking bench for ciob_core: a table of instructions with expected results, then
  branch refusal, mid-run reset and restart. Assumes the bound port checker.
*/
`timescale 1ns/10ps
module tb_ciob_core;
  typedef struct packed {
    logic [1:0] s;
    logic [13:0] i;
    logic [7:0] w;
    logic [7:0] f;
    logic c;
    logic z;
    logic k;
    logic u;
  } ciob_tb_row_t;
  logic clk, rst_n, instr_valid, instr_ready, carry_flag, zero_flag, nop_cycle, retired, unknown_op, rdy_s;
  logic [13:0] instr_word;
  logic [6:0] program_page_latch, peek_addr;
  logic [7:0] peek_data, working_reg;
  logic [14:0] program_counter, exp_pc;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  // Top bits: pc step; nibble: carry, zero, check file, word outside the slice
  ciob_tb_row_t rows [0:24] = '{
    {16'h78FF, 8'hFF, 8'h00, 4'h0}, {16'h4481, 8'hFF, 8'hFF, 4'h2}, {16'h4A81, 8'hFF, 8'h00, 4'h6},
    {16'h44FF, 8'hFF, 8'hFF, 4'h2}, {16'h4A7F, 8'h00, 8'hFF, 4'h6}, {16'h4401, 8'h00, 8'h00, 4'h6},
    {16'h7881, 8'h81, 8'h00, 4'h0}, {16'h4481, 8'h81, 8'h81, 4'h2}, {16'h7501, 8'h02, 8'h81, 4'hA},
    {16'h7581, 8'h02, 8'h02, 4'hA}, {16'h75FF, 8'h02, 8'hFE, 4'hA}, {16'h4A01, 8'h03, 8'h02, 4'hA},
    {16'h4F81, 8'h03, 8'h03, 4'hA}, {16'h4F7F, 8'hFF, 8'hFE, 4'hA}, {16'h4481, 8'hFF, 8'hFF, 4'hA},
    {16'h4A81, 8'hFF, 8'h00, 4'hE}, {16'h7501, 8'h00, 8'h00, 4'h6}, {16'h7800, 8'h00, 8'h00, 4'h4},
    {16'h78FF, 8'hFF, 8'h00, 4'h0}, {16'h4481, 8'hFF, 8'hFF, 4'h2}, {16'h8F81, 8'hFF, 8'h00, 4'h2},
    {16'h44FF, 8'hFF, 8'hFF, 4'h2}, {16'h8F7F, 8'h00, 8'hFF, 4'h2}, {16'h4000, 8'h00, 8'h00, 4'h1},
    {16'h6FFF, 8'h00, 8'h00, 4'h0}};

  ciob_core ciob_core_i (.clk, .rst_n, .instr_valid, .instr_word, .instr_ready, .program_page_latch,
    .peek_addr, .peek_data, .program_counter, .working_reg, .carry_flag, .zero_flag, .nop_cycle,
    .retired, .unknown_op);

  // Clock and a ready sample taken mid-cycle, away from the edge
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  always @(negedge clk) rdy_s <= instr_ready;

  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  task chk(input logic [14:0] g, input logic [14:0] e);
    n_tests = n_tests + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task do_reset;
    rst_n <= 1'h0;
    instr_valid <= 1'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    @(negedge clk);
    exp_pc = 15'h0000;
    chk(program_counter, 15'h0000);
    chk(working_reg, 8'h00);
    chk({carry_flag, zero_flag}, 2'h0);
    chk(instr_ready, 1'h1);
    @(posedge clk);
  endtask : do_reset

  // Present one word, hold it until taken, then compare the results
  task run(input ciob_tb_row_t r);
    int n;
    instr_word <= r.i;
    peek_addr <= r.i[6:0];
    instr_valid <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n = n + 1;
    end while (rdy_s !== 1'h1 && n < 8);
    instr_valid <= 1'h0;
    exp_pc = (r.i[13:11] == 3'h5) ? {program_page_latch[6:3], r.i[10:0]} : exp_pc + r.s;
    @(negedge clk);
    chk(working_reg, r.w);
    chk(carry_flag, r.c);
    chk(zero_flag, r.z);
    chk(program_counter, exp_pc);
    if (r.k) chk(peek_data, r.f);
    chk(retired, 1'h1);
    chk(unknown_op, r.u);
    @(posedge clk);
  endtask : run

  task tally_and_finish;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Table first, then a word held through a branch flush, then reset mid-run
  initial begin
    instr_word = 14'h0000;
    peek_addr = 7'h00;
    program_page_latch = 7'h5A;
    instr_valid = 1'h0;
    rst_n = 1'h0;
    do_reset();
    foreach (rows[j]) run(rows[j]);
    program_page_latch <= 7'h47;
    instr_word <= 14'h2800;
    instr_valid <= 1'h1;
    @(posedge clk);
    instr_word <= 14'h3810;
    // Flush cycle: the OR word stands but must be refused
    @(negedge clk);
    chk(instr_ready, 1'h0);
    chk(program_counter, 15'h4000);
    @(posedge clk);
    @(negedge clk);
    chk(nop_cycle, 1'h1);
    chk(working_reg, 8'h00);
    chk(instr_ready, 1'h1);
    @(posedge clk);
    instr_valid <= 1'h0;
    @(negedge clk);
    chk(program_counter, 15'h4001);
    chk(working_reg, 8'h10);
    @(posedge clk);
    do_reset();
    run(rows[0]);
    tally_and_finish();
  end
endmodule : tb_ciob_core
